/* rh_desc_defines.svh */
`ifndef RH_DESC_DEFINES_SVH
`define RH_DESC_DEFINES_SVH

// register byte addresses
`define RH_CHAR_A_ADR    32'h9010_1048
`define RH_MASKS_ADR     32'h9010_104c

// field positions, first register
`define RH_PGOOD_MSB     31
`define RH_PGOOD_LSB     24
`define RH_RSVD_MSB      23
`define RH_RSVD_LSB      13
`define RH_NO_OVERCURRENT_PROTECT_BIT      12
`define RH_OVERCURRENT_REPORT_MODE_BIT      11
`define RH_DT_BIT        10
`define RH_PSM_BIT       9
`define RH_NPS_BIT       8
`define RH_NDP_MSB       7
`define RH_NDP_LSB       0

// field positions, second register
`define RH_PORT_POWER_CTRL_MASK_MSB      31
`define RH_PORT_POWER_CTRL_MASK_LSB      16
`define RH_DR_MSB        15
`define RH_DR_LSB        0

// reset values and fixed field values
`define RH_PGOOD_RST     8'h0a
`define RH_NO_OVERCURRENT_PROTECT_RST      1'h0
`define RH_OVERCURRENT_REPORT_MODE_RST      1'h1
`define RH_PSM_RST       1'h1
`define RH_NPS_RST       1'h0
`define RH_DT_VAL        1'h0
`define RH_NDP_VAL       8'h04
`define RH_PORT_POWER_CTRL_MASK_RST      16'h0000
`define RH_DR_RST        16'h0000

// whole-word byte select
`define RH_FULL_SEL      4'hf

`endif

/* rh_desc_pkg.sv */
package rh_desc_pkg;

   typedef logic [31:0] word_t;
   typedef logic [15:0] port_vec_t;
   typedef logic [7:0]  byte_t;

   // one bit per existing port, bit 0 never set
   function automatic port_vec_t ports_present(input byte_t count);
      port_vec_t v;
      v = '0;
      for (int n = 1; n < 16; n++) begin
         v[n] = (8'(n) <= count);
      end
      return v;
   endfunction

endpackage

/* rh_port_policy.sv */
`timescale 1ns/10ps
`default_nettype none

// turns the descriptor settings into the effective port policy
module rh_port_policy
   import rh_desc_pkg::*;
(
   input  wire logic      clk_i,
   input  wire logic      rst_i,
   input  wire logic      no_overcurrent_protect_i,
   input  wire logic      overcurrent_report_mode_i,
   input  wire logic      power_switch_mode_i,
   input  wire logic      always_powered_i,
   input  wire byte_t     downstream_port_count_i,
   input  wire port_vec_t port_power_ctrl_mask_i,
   input  wire port_vec_t nonremovable_device_mask_i,
   output port_vec_t      per_port_ctrl_o,
   output port_vec_t      global_ctrl_o,
   output port_vec_t      nonremovable_o,
   output logic           switched_power_o,
   output logic           per_port_power_o,
   output logic           oc_none_o,
   output logic           per_port_oc_o
);

   port_vec_t present;    // ports that exist
   logic      indiv;      // individual switching in force

   always_comb begin
      present = ports_present(downstream_port_count_i);              // [RULE18]
      indiv   = power_switch_mode_i & ~always_powered_i;             // [RULE8]
   end

   // power switching policy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         switched_power_o <= 1'h0;
         per_port_power_o <= 1'h0;
         per_port_ctrl_o  <= '0;
         global_ctrl_o    <= '0;
      end else begin
         switched_power_o <= ~always_powered_i;                      // [RULE9]
         per_port_power_o <= indiv;                                  // [RULE6]
         // masked ports answer only per-port commands
         per_port_ctrl_o  <= indiv ? (port_power_ctrl_mask_i & present) : '0;  // [RULE7] [RULE11]
         // the rest follow only the global switch
         global_ctrl_o    <= (always_powered_i ? '0 :
                              indiv ? (~port_power_ctrl_mask_i & present) : present); // [RULE7]
      end
   end

   // overcurrent and removability policy
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         oc_none_o      <= 1'h0;
         per_port_oc_o  <= 1'h0;
         nonremovable_o <= '0;
      end else begin
         oc_none_o      <= no_overcurrent_protect_i;                 // [RULE2]
         per_port_oc_o  <= overcurrent_report_mode_i &
                           ~no_overcurrent_protect_i;                // [RULE3]
         nonremovable_o <= nonremovable_device_mask_i & present;     // [RULE12] [RULE18]
      end
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   AST_PSM_NEEDS_SWITCHING: assert property ( // [RULE8]
      per_port_power_o |-> $past(~always_powered_i))
      else $error("per-port power while ports are always powered");

   AST_OVERCURRENT_REPORT_MODE_NEEDS_PROTECT: assert property ( // [RULE3]
      per_port_oc_o |-> !oc_none_o)
      else $error("per-port overcurrent while protection is off");

   AST_NO_PHANTOM_PORT: assert property ( // [RULE18]
      ((per_port_ctrl_o | global_ctrl_o | nonremovable_o) &
       ~ports_present($past(downstream_port_count_i))) == '0)
      else $error("policy bit set for a port that does not exist");

endmodule

`default_nettype wire

/* tb_top.sv */
`timescale 1ns/10ps
`default_nettype none

`include "rh_desc_defines.svh"

// compares a seen value with the expected one and counts the check
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin failures++; $display("Error %s expected %h seen %h", nm, e, g); end end

module tb_top
   import rh_desc_pkg::*;
;
   logic      clk_i = 1'b0;   // 200 MHz system clock
   logic      rst_i = 1'b1;   // synchronous reset, held at start
   logic      cyc   = 1'b0;   // bus cycle
   logic      stb   = 1'b0;   // bus strobe
   logic      we    = 1'b0;   // write direction
   word_t     adr   = '0;     // byte address
   word_t     wdat  = '0;     // write data
   logic [3:0] sel  = 4'h0;   // byte lanes
   word_t     wb_dat_o;       // read data
   logic      wb_ack_o;       // acknowledge
   byte_t     pgw;            // power-good wait copy
   byte_t     downstream_port_count;            // port count copy
   logic      sw;             // ports power switched
   logic      ppp;            // individual switching in force
   logic      ocn;            // no overcurrent protection
   logic      ppoc;           // per-port overcurrent reporting
   port_vec_t ppc;            // per-port controlled ports
   port_vec_t gc;             // globally controlled ports
   port_vec_t nr;             // non-removable ports
   int        failures = 0;   // mismatches seen
   int        n_checks = 0;   // comparisons made

   // mode table: written word, read-back word, {sw,ppp,ocn,ppoc}, masks
   word_t     wa[4]   = '{32'h1100_0604, 32'h2200_08ff, 32'h3300_1a04, 32'h44fe_0b04};
   word_t     ra[4]   = '{32'h1100_0204, 32'h2200_0804, 32'h3300_1a04, 32'h4400_0b04};
   logic [3:0] ep[4]  = '{4'hc, 4'h9, 4'he, 4'h1};
   port_vec_t eppc[4] = '{16'h000a, 16'h0000, 16'h000a, 16'h0000};
   port_vec_t egc[4]  = '{16'h0014, 16'h001e, 16'h0014, 16'h0000};

   // clock generator, 5 ns period
   always #2.5 clk_i = ~clk_i;

   usb_root_hub_descriptor_regs usb_root_hub_descriptor_regs_i (
      .clk_i                   (clk_i),
      .rst_i                   (rst_i),
      .wb_cyc_i                (cyc),
      .wb_stb_i                (stb),
      .wb_we_i                 (we),
      .wb_adr_i                (adr),
      .wb_sel_i                (sel),
      .wb_dat_i                (wdat),
      .wb_dat_o                (wb_dat_o),
      .wb_ack_o                (wb_ack_o),
      .power_good_wait_time_o  (pgw),
      .downstream_port_count_o (downstream_port_count),
      .switched_power_o        (sw),
      .per_port_power_o        (ppp),
      .oc_none_o               (ocn),
      .per_port_oc_o           (ppoc),
      .per_port_ctrl_o         (ppc),
      .global_ctrl_o           (gc),
      .nonremovable_o          (nr)
   );

   // prints the counts and the verdict, then stops
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, failures);
      if (failures == 0 && n_checks > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask

   // one classic single cycle, held until ack is sampled high
   task automatic wb_xfer(input logic w, input word_t a, input logic [3:0] s,
                          input word_t d, output word_t q);
      int n;
      @(posedge clk_i);
      cyc  <= 1'b1;
      stb  <= 1'b1;
      we   <= w;
      adr  <= a;
      sel  <= s;
      wdat <= d;
      n = 0;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (wb_ack_o !== 1'b1) begin
         failures++;
         $display("Error ack expected 1 seen timeout");
         end_of_test;
      end
      cyc <= 1'b0;
      stb <= 1'b0;
      we  <= 1'b0;
      sel <= 4'h0;
   endtask

   // write a word, whole lanes unless told otherwise
   task automatic wr(input word_t a, input word_t d, input logic [3:0] s = 4'hf);
      word_t q;
      wb_xfer(1'b1, a, s, d, q);
   endtask

   // read a word and compare it
   task automatic rd_chk(input word_t a, input word_t e, input string nm);
      word_t q;
      wb_xfer(1'b0, a, 4'hf, '0, q);
      `CHK(nm, e, q)
   endtask

   // let the policy outputs follow the registers
   task automatic settle;
      repeat (2) @(posedge clk_i);
      #1;
   endtask

   // compares all policy outputs
   task automatic chk_pol(input logic [3:0] e, input port_vec_t e_ppc, input port_vec_t e_gc,
                          input port_vec_t e_nr);
      `CHK("switched_power", e[3], sw)
      `CHK("per_port_power", e[2], ppp)
      `CHK("oc_none", e[1], ocn)
      `CHK("per_port_oc", e[0], ppoc)
      `CHK("per_port_ctrl", e_ppc, ppc)
      `CHK("global_ctrl", e_gc, gc)
      `CHK("nonremovable", e_nr, nr)
   endtask

   // main sequence
   initial begin
      repeat (20) @(posedge clk_i);
      rst_i <= 1'b0;
      settle;
      rd_chk(`RH_CHAR_A_ADR, 32'h0a00_0a04, "reg a reset");
      rd_chk(`RH_MASKS_ADR, 32'h0000_0000, "reg b reset");
      `CHK("wait", 8'h0a, pgw)
      `CHK("count", 8'h04, downstream_port_count)
      chk_pol(4'hd, 16'h0000, 16'h001e, 16'h0000);
      $display("test reset_values done");
      // configuration writes, made as driver software does at start-up
      wr(`RH_CHAR_A_ADR, 32'hffff_ffff);
      rd_chk(`RH_CHAR_A_ADR, 32'hff00_1b04, "reg a ones");
      wr(`RH_MASKS_ADR, 32'hffff_ffff);
      rd_chk(`RH_MASKS_ADR, 32'hfffe_fffe, "reg b ones");
      settle;
      `CHK("wait", 8'hff, pgw)
      chk_pol(4'h2, 16'h0000, 16'h0000, 16'h001e);
      $display("test all_ones done");
      wr(`RH_MASKS_ADR, 32'h000a_0014);
      for (int i = 0; i < 4; i++) begin
         wr(`RH_CHAR_A_ADR, wa[i]);
         rd_chk(`RH_CHAR_A_ADR, ra[i], "reg a mode");
         settle;
         `CHK("wait", wa[i][31:24], pgw)
         chk_pol(ep[i], eppc[i], egc[i], 16'h0014);
      end
      $display("test modes done");
      wr(`RH_CHAR_A_ADR, 32'h0000_0000, 4'h3);
      rd_chk(`RH_CHAR_A_ADR, 32'h4400_0b04, "reg a part");
      wr(32'h9010_1050, 32'hffff_ffff);
      rd_chk(32'h9010_1050, 32'h0000_0000, "unmapped");
      rd_chk(`RH_MASKS_ADR, 32'h000a_0014, "reg b kept");
      settle;
      `CHK("idle data", 32'h0000_0000, wb_dat_o)
      $display("test refused done");
      @(posedge clk_i);
      rst_i <= 1'b1;
      repeat (2) @(posedge clk_i);
      rst_i <= 1'b0;
      settle;
      rd_chk(`RH_CHAR_A_ADR, 32'h0a00_0a04, "reg a rereset");
      rd_chk(`RH_MASKS_ADR, 32'h0000_0000, "reg b rereset");
      $display("test mid_reset done");
      end_of_test;
   end

endmodule

`default_nettype wire

/* usb_root_hub_descriptor_regs.sv */
`timescale 1ns/10ps
`default_nettype none

`include "rh_desc_defines.svh"

// How it works
// [RULE1] top byte: power-good wait, 2 ms units
// [RULE2] no-protection bit, read/write
// [RULE3] report mode honoured only with protection present
// [RULE4] report mode resets equal to switching mode
// [RULE5] compound-device bit always reads zero
// [RULE6] switching mode: ganged or individual ports
// [RULE7] masked ports per-port only, others global
// [RULE8] switching mode honoured only if switched
// [RULE9] always-powered bit, read/write
// [RULE10] port count read-only, between 1 and 15
// [RULE11] power control mask, upper half, bit0 reserved
// [RULE12] non-removable mask, lower half, bit0 reserved
// [RULE13] chosen reset values, compound bit zero
// [RULE14] software waits power-good time before access
// [RULE15] registers accessed only as whole words
// [RULE16] writes accepted in every USB state
// [RULE17] software writes only during initialisation
// [RULE18] masks beyond port count have no effect
// [RULE19] reserved bits 23..13 read zero
module usb_root_hub_descriptor_regs
   import rh_desc_pkg::*;
(
   input  wire logic  clk_i,
   input  wire logic  rst_i,
   // classic wishbone slave
   input  wire logic  wb_cyc_i,
   input  wire logic  wb_stb_i,
   input  wire logic  wb_we_i,
   input  wire word_t wb_adr_i,
   input  wire logic [3:0] wb_sel_i,
   input  wire word_t wb_dat_i,
   output word_t      wb_dat_o,
   output logic       wb_ack_o,
   // settings for the power and overcurrent logic
   output byte_t      power_good_wait_time_o,
   output byte_t      downstream_port_count_o,
   output logic       switched_power_o,
   output logic       per_port_power_o,
   output logic       oc_none_o,
   output logic       per_port_oc_o,
   output port_vec_t  per_port_ctrl_o,
   output port_vec_t  global_ctrl_o,
   output port_vec_t  nonremovable_o
);

   // stored fields

   byte_t     power_good_wait_time_r;    // wait, 2 ms units
   logic      no_overcurrent_protect_r;  // 1: no protection
   logic      overcurrent_report_mode_r; // 1: per-port report
   logic      power_switch_mode_r;       // 1: individual power
   logic      always_powered_r;          // 1: never switched
   port_vec_t port_power_ctrl_mask_r;    // per-port power mask
   port_vec_t nonremovable_device_mask_r; // fixed devices

   // bus decode

   logic  req;        // new request this cycle
   logic  hit_a;      // first register addressed
   logic  hit_b;      // second register addressed
   logic  full_word;  // all four byte lanes selected
   logic  wr_a;       // accepted write, first register
   logic  wr_b;       // accepted write, second register
   word_t rd_nxt;     // read data to present with ack

   // whole 32-bit address compare, shared by both register decodes
   function automatic logic adr_is(input word_t a, input word_t reg_adr);
      return (a == reg_adr);
   endfunction

   // request seen while no ack is out
   always_comb begin
      req       = wb_cyc_i & wb_stb_i & ~wb_ack_o;
      hit_a     = adr_is(wb_adr_i, `RH_CHAR_A_ADR);
      hit_b     = adr_is(wb_adr_i, `RH_MASKS_ADR);
      // partial lanes would split a field
      full_word = (wb_sel_i == `RH_FULL_SEL);               // [RULE15]
      // no USB-state gating on these writes
      wr_a      = req & wb_we_i & full_word & hit_a;        // [RULE16]
      wr_b      = req & wb_we_i & full_word & hit_b;        // [RULE16]
   end

   // read word assembly
   always_comb begin
      rd_nxt = '0;
      if (hit_a) begin
         rd_nxt[`RH_PGOOD_MSB:`RH_PGOOD_LSB] = power_good_wait_time_r; // [RULE1]
         // bits 23..13 stay zero
         rd_nxt[`RH_RSVD_MSB:`RH_RSVD_LSB]   = '0;            // [RULE19]
         rd_nxt[`RH_NO_OVERCURRENT_PROTECT_BIT]  = no_overcurrent_protect_r;    // [RULE2]
         rd_nxt[`RH_OVERCURRENT_REPORT_MODE_BIT]  = overcurrent_report_mode_r;   // [RULE3]
         rd_nxt[`RH_DT_BIT]    = `RH_DT_VAL;                  // [RULE5]
         rd_nxt[`RH_PSM_BIT]   = power_switch_mode_r;         // [RULE6]
         rd_nxt[`RH_NPS_BIT]   = always_powered_r;            // [RULE9]
         rd_nxt[`RH_NDP_MSB:`RH_NDP_LSB] = `RH_NDP_VAL;       // [RULE10]
      end else if (hit_b) begin
         rd_nxt[`RH_PORT_POWER_CTRL_MASK_MSB:`RH_PORT_POWER_CTRL_MASK_LSB] = port_power_ctrl_mask_r;    // [RULE11]
         rd_nxt[`RH_DR_MSB:`RH_DR_LSB]     = nonremovable_device_mask_r; // [RULE12]
      end else begin
         // unmapped address reads as zero
         rd_nxt = '0;
      end
   end

   // bus answer

   // ack one cycle after the request, dropped the cycle after
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_ack_o <= 1'h0;
      end else begin
         wb_ack_o <= req;
      end
   end

   // read data registered together with ack
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         wb_dat_o <= '0;
      end else if (req && !wb_we_i) begin
         // whole word always returned
         wb_dat_o <= rd_nxt;                                  // [RULE15]
      end else begin
         wb_dat_o <= '0;
      end
   end

   // first register fields

   // power-good wait byte
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_good_wait_time_r <= `RH_PGOOD_RST;             // [RULE13]
      end else if (wr_a) begin
         power_good_wait_time_r <= wb_dat_i[`RH_PGOOD_MSB:`RH_PGOOD_LSB]; // [RULE1]
      end
   end

   // overcurrent settings
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         no_overcurrent_protect_r  <= `RH_NO_OVERCURRENT_PROTECT_RST;           // [RULE13]
         // reporting starts in the same mode as switching
         overcurrent_report_mode_r <= `RH_OVERCURRENT_REPORT_MODE_RST;           // [RULE4]
      end else if (wr_a) begin
         no_overcurrent_protect_r  <= wb_dat_i[`RH_NO_OVERCURRENT_PROTECT_BIT]; // [RULE2]
         overcurrent_report_mode_r <= wb_dat_i[`RH_OVERCURRENT_REPORT_MODE_BIT]; // [RULE3]
      end
   end

   // power switching settings
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_switch_mode_r <= `RH_PSM_RST;                  // [RULE13]
         always_powered_r    <= `RH_NPS_RST;                  // [RULE13]
      end else if (wr_a) begin
         power_switch_mode_r <= wb_dat_i[`RH_PSM_BIT];        // [RULE6]
         always_powered_r    <= wb_dat_i[`RH_NPS_BIT];        // [RULE9]
      end
   end

   // second register fields

   // both masks; bit 0 is reserved and kept zero
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         port_power_ctrl_mask_r     <= `RH_PORT_POWER_CTRL_MASK_RST;          // [RULE13]
         nonremovable_device_mask_r <= `RH_DR_RST;            // [RULE13]
      end else if (wr_b) begin
         port_power_ctrl_mask_r <=
            {wb_dat_i[`RH_PORT_POWER_CTRL_MASK_MSB:`RH_PORT_POWER_CTRL_MASK_LSB+1], 1'h0};    // [RULE11]
         nonremovable_device_mask_r <=
            {wb_dat_i[`RH_DR_MSB:`RH_DR_LSB+1], 1'h0};        // [RULE12]
      end
   end

   // plain setting outputs

   // copies for the port logic
   always_ff @(posedge clk_i) begin
      if (rst_i) begin
         power_good_wait_time_o  <= `RH_PGOOD_RST;
         downstream_port_count_o <= `RH_NDP_VAL;
      end else begin
         // software times the wait from this value
         power_good_wait_time_o  <= power_good_wait_time_r;   // [RULE1]
         downstream_port_count_o <= `RH_NDP_VAL;              // [RULE10]
      end
   end

   // effective port policy

   rh_port_policy u_policy (
      .clk_i                      (clk_i),
      .rst_i                      (rst_i),
      .no_overcurrent_protect_i   (no_overcurrent_protect_r),
      .overcurrent_report_mode_i  (overcurrent_report_mode_r),
      .power_switch_mode_i        (power_switch_mode_r),
      .always_powered_i           (always_powered_r),
      .downstream_port_count_i    (`RH_NDP_VAL),
      .port_power_ctrl_mask_i     (port_power_ctrl_mask_r),
      .nonremovable_device_mask_i (nonremovable_device_mask_r),
      .per_port_ctrl_o            (per_port_ctrl_o),
      .global_ctrl_o              (global_ctrl_o),
      .nonremovable_o             (nonremovable_o),
      .switched_power_o           (switched_power_o),
      .per_port_power_o           (per_port_power_o),
      .oc_none_o                  (oc_none_o),
      .per_port_oc_o              (per_port_oc_o)
   );

   // checks

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (rst_i);

   // a whole-word write to the first register
   sequence s_write_a;
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
      wb_sel_i == `RH_FULL_SEL && wb_adr_i == `RH_CHAR_A_ADR;
   endsequence

   // a whole-word write to the second register
   sequence s_write_b;
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
      wb_sel_i == `RH_FULL_SEL && wb_adr_i == `RH_MASKS_ADR;
   endsequence

   // a read request of the first register
   sequence s_read_a;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
      wb_adr_i == `RH_CHAR_A_ADR;
   endsequence

   // a read request of the second register
   sequence s_read_b;
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i &&
      wb_adr_i == `RH_MASKS_ADR;
   endsequence

   AST_ACK_ONE_CYCLE: assert property ( // [RULE16]
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("ack not given one cycle after request");

   AST_POWER_GOOD_WAIT_TIME_WRITE: assert property ( // [RULE1]
      s_write_a |=> power_good_wait_time_r == $past(wb_dat_i[`RH_PGOOD_MSB:`RH_PGOOD_LSB])
                    ##1 power_good_wait_time_o ==
                        $past(wb_dat_i[`RH_PGOOD_MSB:`RH_PGOOD_LSB], 2))
      else $error("power-good wait not written");

   AST_MODE_BITS_WRITE: assert property ( // [RULE6]
      s_write_a |=> power_switch_mode_r == $past(wb_dat_i[`RH_PSM_BIT]) &&
                    always_powered_r == $past(wb_dat_i[`RH_NPS_BIT]) &&
                    no_overcurrent_protect_r == $past(wb_dat_i[`RH_NO_OVERCURRENT_PROTECT_BIT]))
      else $error("mode bits not written");

   AST_READ_FIXED_BITS: assert property ( // [RULE5]
      s_read_a |=> wb_ack_o && wb_dat_o[`RH_DT_BIT] == `RH_DT_VAL &&
                   wb_dat_o[`RH_RSVD_MSB:`RH_RSVD_LSB] == '0)
      else $error("compound or reserved bits read nonzero");

   AST_PORT_COUNT: assert property ( // [RULE10]
      s_read_a |=> wb_dat_o[`RH_NDP_MSB:`RH_NDP_LSB] >= 8'h01 &&
                   wb_dat_o[`RH_NDP_MSB:`RH_NDP_LSB] <= 8'h0f)
      else $error("port count out of range");

   AST_PARTIAL_IGNORED: assert property ( // [RULE15]
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i &&
      wb_sel_i != `RH_FULL_SEL |=>
         $stable(power_good_wait_time_r) && $stable(port_power_ctrl_mask_r) &&
         $stable(nonremovable_device_mask_r) && $stable(power_switch_mode_r))
      else $error("partial write changed a register");

   AST_MASK_WRITE: assert property ( // [RULE11]
      s_write_b |=>
         port_power_ctrl_mask_r == {$past(wb_dat_i[`RH_PORT_POWER_CTRL_MASK_MSB:`RH_PORT_POWER_CTRL_MASK_LSB+1]), 1'h0} &&
         nonremovable_device_mask_r == {$past(wb_dat_i[`RH_DR_MSB:`RH_DR_LSB+1]), 1'h0})
      else $error("mask write wrong");

   AST_RESET_VALUES: assert property ( // [RULE13]
      $fell(rst_i) |-> overcurrent_report_mode_r == `RH_OVERCURRENT_REPORT_MODE_RST &&
                       power_good_wait_time_r == `RH_PGOOD_RST)
      else $error("reset value not loaded");

   AST_OVERCURRENT_REPORT_MODE_PAIRS_PSM: assert property ( // [RULE4]
      $fell(rst_i) |-> overcurrent_report_mode_r == power_switch_mode_r)
      else $error("report mode reset differs from switching mode");

   AST_GLOBAL_MASK_IGNORED: assert property ( // [RULE11]
      !power_switch_mode_r && !wr_a ##2 1'h1 |-> per_port_ctrl_o == '0)
      else $error("mask acted in ganged mode");

   // ack is a single-cycle pulse
   AST_ACK_PULSE: assert property ( // [RULE15]
      wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");

   // read data bus is quiet outside the answer cycle
   AST_IDLE_DATA_ZERO: assert property ( // [RULE15]
      !wb_ack_o |-> wb_dat_o == '0)
      else $error("read data driven without ack");

   // report mode bit lands with a first-register write
   AST_OVERCURRENT_REPORT_MODE_WRITE: assert property ( // [RULE3]
      s_write_a |=> overcurrent_report_mode_r == $past(wb_dat_i[`RH_OVERCURRENT_REPORT_MODE_BIT]))
      else $error("report mode bit not written");

   // second register reads back both masks as stored
   AST_READ_B: assert property ( // [RULE12]
      s_read_b |=> wb_ack_o &&
         wb_dat_o == {$past(port_power_ctrl_mask_r), $past(nonremovable_device_mask_r)})
      else $error("mask read-back wrong");

   // reserved bit 0 of each mask never holds a one
   AST_MASK_BIT0_ZERO: assert property ( // [RULE11] [RULE12]
      port_power_ctrl_mask_r[0] == 1'h0 &&
      nonremovable_device_mask_r[0] == 1'h0)
      else $error("reserved mask bit set");

   // port count copy never moves
   AST_COUNT_OUT: assert property ( // [RULE10]
      downstream_port_count_o == `RH_NDP_VAL)
      else $error("port count output changed");

   // wait copy follows the stored byte one cycle later
   AST_PGOOD_COPY: assert property ( // [RULE1]
      !$past(rst_i) |-> power_good_wait_time_o == $past(power_good_wait_time_r))
      else $error("power-good wait copy lags wrongly");

   // unmapped reads answer with an all-zero word
   AST_UNMAPPED_READ: assert property ( // [RULE15]
      wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_we_i && !hit_a && !hit_b |=>
         wb_ack_o && wb_dat_o == '0)
      else $error("unmapped read returned data");

   // unmapped writes leave the wait byte, no-protection bit, power mask and always-powered bit alone
   AST_UNMAPPED_WRITE: assert property ( // [RULE15]
      wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && !hit_a && !hit_b |=>
         $stable(power_good_wait_time_r) && $stable(no_overcurrent_protect_r) &&
         $stable(port_power_ctrl_mask_r) && $stable(always_powered_r))
      else $error("unmapped write changed a register");

   // first register reads back the wait byte, report mode bit and always-powered bit in place
   AST_READ_A_FIELDS: assert property ( // [RULE1]
      s_read_a |=> wb_dat_o[`RH_PGOOD_MSB:`RH_PGOOD_LSB] == $past(power_good_wait_time_r) &&
         wb_dat_o[`RH_OVERCURRENT_REPORT_MODE_BIT] == $past(overcurrent_report_mode_r) &&
         wb_dat_o[`RH_NPS_BIT] == $past(always_powered_r))
      else $error("first register field read back wrong");

endmodule

`default_nettype wire
